// ### hdl/iof_top.v
// Purpose: I/O bus device front end with flags, strobes and data channel
// Assumes: software issues bus instructions through the register file
// Notes: strobes are one clock wide at the user-side polarity
// Function
// - Start: busy set, done cleared, start strobe
// - Clear: busy and done cleared, clear strobe
// - Pulse: done cleared only, special strobe
// - Strobe first, then transfer, then flag function
// - No-transfer: no-operation strobe, then flag function
// - Input A/B/C: strobe, capture user data
// - Output A/B/C: strobe, drive accumulator to user
// - Skip test: select lines follow busy, done
// - Bus reset clears busy and done
// - Bus reset reloads device code and polarity
// - Mask out: strobe, AND inputs, disable interrupt
// - Acknowledge returns code when requesting and first
// - B register loadable and readable, C load-only
// - Data channel: B is address, C count
// - Address is 15 bits, count 16 bits
// - Strobes serve three user input, output registers
// - Decode, request interrupts and channel, transfer words
// - Holds channel request, interrupt request, disable flags
// - Holds external, polarity and device code settings
// - Data split into output and input groups
// - External selection swaps internal registers for user's
// - Polarity selection picks user-side logic sense
// - Device code bits set from six straps
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "iof_defs.vh"
module iof_top #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // AXI4-Lite register bus
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // User data groups
  input wire [15:0] user_din,
  output wire [15:0] user_dout,
  // User command strobes
  output wire no_operation_strobe,
  output wire input_a_strobe,
  output wire input_b_strobe,
  output wire input_c_strobe,
  output wire output_a_strobe,
  output wire output_b_strobe,
  output wire output_c_strobe,
  output wire start_strobe,
  output wire clear_strobe,
  output wire special_pulse_strobe,
  output wire mask_out_strobe,
  output wire dch_xfer_strobe,
  // User requests
  input wire dev_complete,
  input wire dch_req_in,
  // Bus-side status
  output wire busy_select_line,
  output wire done_select_line,
  output wire int_req,
  output wire dch_req,
  input wire prio_in,
  output wire prio_out,
  // Straps
  input wire [5:0] strap_dev_code,
  input wire strap_external,
  input wire strap_polarity
);
  localparam ST_IDLE = 2'h0;
  localparam ST_STRB = 2'h1;
  localparam ST_XFER = 2'h2;
  localparam ST_FLAG = 2'h3;

  wire wr_en;
  wire [AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [AW-1:0] rd_addr;
  reg [31:0] rd_data;
  wire [26:0] sync_out;
  wire [15:0] din_s;
  wire [5:0] code_s;
  wire ext_s, pol_s, prio_s, dreq_s, cmpl_s;

  reg [1:0] st_q;
  reg [15:0] ins_q, acc_q, in_q, dout_q, wcnt_q;
  reg [14:0] addr_q;
  reg busy_q, done_q, int_dis_q, int_req_q, dch_req_q;
  reg ext_q, pol_q, skip_q, sel_b_q, sel_d_q, prio_out_q;
  reg dreq_prev_q, cmpl_prev_q;
  reg [5:0] dev_q;
  reg [1:0] load_q;
  reg [`IOF_NSTB-1:0] stb_q;
  reg [`IOF_NSTB-1:0] act_d;
  reg busy_d, done_d, skip_d;

  function hit;
    input [AW-1:0] a;
    input [4:0] off;
    begin
      hit = ~|a[AW-1:5] && (a[4:2] == off[4:2]);
    end
  endfunction

  iof_axil #(.AW(AW)) u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hold(st_q != ST_IDLE),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  iof_sync #(.W(27)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({dev_complete, dch_req_in, prio_in, strap_polarity, strap_external,
        strap_dev_code, user_din}),
    .q(sync_out)
  );
  assign din_s = sync_out[15:0];
  assign code_s = sync_out[21:16];
  assign ext_s = sync_out[22];
  assign pol_s = sync_out[23];
  assign prio_s = sync_out[24];
  assign dreq_s = sync_out[25];
  assign cmpl_s = sync_out[26];

  // Fields of the latched and of the incoming instruction
  wire [2:0] xfer = ins_q[`IOF_F_XFER_HI:`IOF_F_XFER_LO];
  wire [1:0] fn = ins_q[`IOF_F_FN_HI:`IOF_F_FN_LO];
  wire [5:0] dev = ins_q[`IOF_F_DEV_HI:`IOF_F_DEV_LO];
  wire cpu = (dev == `IOF_DEV_CPU);
  wire [2:0] w_xfer = wr_data[`IOF_F_XFER_HI:`IOF_F_XFER_LO];
  wire [5:0] w_dev = wr_data[`IOF_F_DEV_HI:`IOF_F_DEV_LO];
  wire w_cpu_ok = (w_xfer == `IOF_X_OUT_A) || (w_xfer == `IOF_X_OUT_B) ||
                  (w_xfer == `IOF_X_IN_B);
  wire w_match = (w_dev == `IOF_DEV_CPU) ? w_cpu_ok : (w_dev == dev_q);
  wire issue = wr_en && hit(wr_addr, `IOF_A_INSTR) && (st_q == ST_IDLE);
  wire dch_go = wr_en && hit(wr_addr, `IOF_A_DCH) && (st_q == ST_IDLE) && dch_req_q;
  wire in_xfer = (st_q == ST_XFER);
  wire in_flag = (st_q == ST_FLAG) && !cpu && (xfer != `IOF_X_TEST);
  wire bus_reset = in_xfer && cpu && (xfer == `IOF_X_OUT_A);
  wire step_int = dch_go && !ext_q;
  wire cmpl_rise = cmpl_s && !cmpl_prev_q;

  // Command strobes in the strobe state, flag strobes last
  always @* begin
    act_d = {`IOF_NSTB{1'b0}};
    if (st_q == ST_STRB && !cpu) begin
      case (xfer)
        `IOF_X_NONE: act_d[`IOF_S_NOP] = 1'b1;
        `IOF_X_IN_A: act_d[`IOF_S_IA] = 1'b1;
        `IOF_X_IN_B: act_d[`IOF_S_IB] = 1'b1;
        `IOF_X_IN_C: act_d[`IOF_S_IC] = 1'b1;
        `IOF_X_OUT_A: act_d[`IOF_S_OA] = 1'b1;
        `IOF_X_OUT_B: act_d[`IOF_S_OB] = 1'b1;
        `IOF_X_OUT_C: act_d[`IOF_S_OC] = 1'b1;
        default: act_d[`IOF_S_NOP] = 1'b0;
      endcase
    end
    if (st_q == ST_STRB && cpu && xfer == `IOF_X_OUT_B) begin
      act_d[`IOF_S_MK] = 1'b1;
    end
    if (in_flag) begin
      case (fn)
        `IOF_FN_START: act_d[`IOF_S_ST] = 1'b1;
        `IOF_FN_CLEAR: act_d[`IOF_S_CL] = 1'b1;
        `IOF_FN_PULSE: act_d[`IOF_S_PL] = 1'b1;
        default: act_d[`IOF_S_ST] = 1'b0;
      endcase
    end
    if (dch_go) begin
      act_d[`IOF_S_DX] = 1'b1;
    end
  end

  // Flags: hardware sets win over clears in the same cycle
  always @* begin
    busy_d = busy_q;
    done_d = done_q;
    if (in_flag && fn == `IOF_FN_START) begin
      busy_d = 1'b1;
      done_d = 1'b0;
    end
    if (in_flag && fn == `IOF_FN_CLEAR) begin
      busy_d = 1'b0;
      done_d = 1'b0;
    end
    if (in_flag && fn == `IOF_FN_PULSE) begin
      done_d = 1'b0;
    end
    if (bus_reset) begin
      busy_d = 1'b0;
      done_d = 1'b0;
    end
    if (cmpl_rise) begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end
    if (step_int && wcnt_q == 16'hFFFF) begin
      done_d = 1'b1;
    end
  end

  always @* begin
    case (fn)
      `IOF_T_BUSY1: skip_d = busy_q;
      `IOF_T_BUSY0: skip_d = !busy_q;
      `IOF_T_DONE1: skip_d = done_q;
      default: skip_d = !done_q;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      ins_q <= 16'h0000;
      acc_q <= 16'h0000;
      in_q <= 16'h0000;
      dout_q <= 16'h0000;
      wcnt_q <= 16'h0000;
      addr_q <= 15'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      int_dis_q <= 1'b0;
      int_req_q <= 1'b0;
      dch_req_q <= 1'b0;
      ext_q <= 1'b0;
      pol_q <= 1'b0;
      skip_q <= 1'b0;
      sel_b_q <= 1'b0;
      sel_d_q <= 1'b0;
      prio_out_q <= 1'b0;
      dreq_prev_q <= 1'b0;
      cmpl_prev_q <= 1'b0;
      dev_q <= `IOF_DEV_RST;
      load_q <= `IOF_STRAP_SETTLE;
      stb_q <= `IOF_STB_RST;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      dreq_prev_q <= dreq_s;
      cmpl_prev_q <= cmpl_s;
      stb_q <= act_d ^ {`IOF_NSTB{~pol_q}};
      int_req_q <= done_q && !int_dis_q;
      prio_out_q <= prio_s && !int_req_q;
      dch_req_q <= (dreq_s && !dreq_prev_q) || (dch_req_q && !dch_go);
      sel_b_q <= in_xfer && !cpu && (xfer == `IOF_X_TEST) && busy_q;
      sel_d_q <= in_xfer && !cpu && (xfer == `IOF_X_TEST) && done_q;
      // Straps settle through the synchroniser before they are taken
      if (load_q != 2'h0) begin
        load_q <= load_q - 2'h1;
      end
      if (load_q != 2'h0 || bus_reset) begin
        dev_q <= code_s;
        ext_q <= ext_s;
        pol_q <= pol_s;
      end
      if (wr_en && hit(wr_addr, `IOF_A_ACC)) begin
        if (wr_strb[0]) begin
          acc_q[7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          acc_q[15:8] <= wr_data[15:8];
        end
      end
      case (st_q)
        ST_IDLE: begin
          if (issue) begin
            ins_q <= wr_data[15:0];
            if (w_match) begin
              st_q <= ST_STRB;
            end
          end
        end
        ST_STRB: st_q <= ST_XFER;
        ST_XFER: st_q <= ST_FLAG;
        default: st_q <= ST_IDLE;
      endcase
      if (in_xfer && cpu) begin
        case (xfer)
          `IOF_X_OUT_B: int_dis_q <= |(din_s & acc_q);
          `IOF_X_IN_B: in_q <= (int_req_q && prio_s) ? {10'h000, dev_q} : 16'h0000;
          default: in_q <= in_q;
        endcase
      end
      if (in_xfer && !cpu) begin
        case (xfer)
          `IOF_X_IN_A: in_q <= din_s;
          `IOF_X_IN_C: in_q <= din_s;
          `IOF_X_IN_B: in_q <= ext_q ? din_s : {1'b0, addr_q};
          `IOF_X_OUT_A: dout_q <= acc_q;
          `IOF_X_OUT_B: begin
            dout_q <= acc_q;
            if (!ext_q) begin
              addr_q <= acc_q[14:0];
            end
          end
          `IOF_X_OUT_C: begin
            dout_q <= acc_q;
            if (!ext_q) begin
              wcnt_q <= acc_q;
            end
          end
          `IOF_X_TEST: skip_q <= skip_d;
          default: dout_q <= dout_q;
        endcase
      end
      if (dch_go) begin
        dout_q <= wr_data[15:0];
      end
      if (step_int) begin
        addr_q <= addr_q + 15'h0001;
        wcnt_q <= wcnt_q + 16'h0001;
      end
    end
  end

  // Read decode; word count stays write-only on purpose
  always @* begin
    if (hit(rd_addr, `IOF_A_ACC)) begin
      rd_data = {16'h0000, acc_q};
    end else if (hit(rd_addr, `IOF_A_INSTR)) begin
      rd_data = {16'h0000, ins_q};
    end else if (hit(rd_addr, `IOF_A_INPUT)) begin
      rd_data = {16'h0000, in_q};
    end else if (hit(rd_addr, `IOF_A_STATUS)) begin
      rd_data = {16'h0000, dev_q, 1'b0, st_q != ST_IDLE, skip_q, pol_q, ext_q,
                 dch_req_q, int_dis_q, int_req_q, done_q, busy_q};
    end else if (hit(rd_addr, `IOF_A_ADDR)) begin
      rd_data = {17'h00000, addr_q};
    end else begin
      rd_data = 32'h00000000;
    end
  end

  assign user_dout = dout_q;
  assign no_operation_strobe = stb_q[`IOF_S_NOP];
  assign input_a_strobe = stb_q[`IOF_S_IA];
  assign input_b_strobe = stb_q[`IOF_S_IB];
  assign input_c_strobe = stb_q[`IOF_S_IC];
  assign output_a_strobe = stb_q[`IOF_S_OA];
  assign output_b_strobe = stb_q[`IOF_S_OB];
  assign output_c_strobe = stb_q[`IOF_S_OC];
  assign start_strobe = stb_q[`IOF_S_ST];
  assign clear_strobe = stb_q[`IOF_S_CL];
  assign special_pulse_strobe = stb_q[`IOF_S_PL];
  assign mask_out_strobe = stb_q[`IOF_S_MK];
  assign dch_xfer_strobe = stb_q[`IOF_S_DX];
  assign busy_select_line = sel_b_q;
  assign done_select_line = sel_d_q;
  assign int_req = int_req_q;
  assign dch_req = dch_req_q;
  assign prio_out = prio_out_q;
endmodule // iof_top

// ### common/iof_defs.vh
// Purpose: constants for the I/O bus device front end
// Assumes: included by bare name from the top module and the bench
// Notes: instruction word uses bit 0 as the least significant bit
`ifndef IOF_DEFS_VH
`define IOF_DEFS_VH
// Register byte offsets
`define IOF_A_ACC 5'h00
`define IOF_A_INSTR 5'h04
`define IOF_A_INPUT 5'h08
`define IOF_A_STATUS 5'h0C
`define IOF_A_ADDR 5'h10
`define IOF_A_DCH 5'h18
// Instruction word fields
`define IOF_F_XFER_HI 10
`define IOF_F_XFER_LO 8
`define IOF_F_FN_HI 7
`define IOF_F_FN_LO 6
`define IOF_F_DEV_HI 5
`define IOF_F_DEV_LO 0
// Transfer codes
`define IOF_X_NONE 3'h0
`define IOF_X_IN_A 3'h1
`define IOF_X_OUT_A 3'h2
`define IOF_X_IN_B 3'h3
`define IOF_X_OUT_B 3'h4
`define IOF_X_IN_C 3'h5
`define IOF_X_OUT_C 3'h6
`define IOF_X_TEST 3'h7
// Flag functions
`define IOF_FN_NONE 2'h0
`define IOF_FN_START 2'h1
`define IOF_FN_CLEAR 2'h2
`define IOF_FN_PULSE 2'h3
// Skip test conditions
`define IOF_T_BUSY1 2'h0
`define IOF_T_BUSY0 2'h1
`define IOF_T_DONE1 2'h2
`define IOF_T_DONE0 2'h3
// Processor device code
`define IOF_DEV_CPU 6'h3F
// Strobe vector bit positions
`define IOF_S_NOP 0
`define IOF_S_IA 1
`define IOF_S_IB 2
`define IOF_S_IC 3
`define IOF_S_OA 4
`define IOF_S_OB 5
`define IOF_S_OC 6
`define IOF_S_ST 7
`define IOF_S_CL 8
`define IOF_S_PL 9
`define IOF_S_MK 10
`define IOF_S_DX 11
`define IOF_NSTB 12
// Reset values
`define IOF_STB_RST 12'hFFF
`define IOF_DEV_RST 6'h00
`define IOF_STRAP_SETTLE 2'h3
`endif

// ### hdl/iof_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: bits are independent levels
// Notes: multi-bit words may tear for one cycle
`timescale 1ns/1ps
module iof_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // iof_sync

// ### hdl/iof_axil.v
// Purpose: AXI4-Lite slave front for the register file
// Assumes: one write and one read outstanding at most
// Notes: response always OKAY; unmapped writes dropped, reads zero
`timescale 1ns/1ps
module iof_axil #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // AXI4-Lite
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Register side
  input wire hold,
  output wire wr_en,
  output wire [AW-1:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb,
  output wire [AW-1:0] rd_addr,
  input wire [31:0] rd_data
);
  reg aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, wr_en_q;
  reg arready_q, rvalid_q;
  reg [AW-1:0] awaddr_q;
  reg [31:0] wdata_q, rdata_q;
  reg [3:0] wstrb_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      wr_en_q <= 1'b0;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      wr_en_q <= 1'b0;
      // Hold keeps new writes out while a command sequence runs
      awready_q <= !aw_have_q && !(s_axi_awvalid && awready_q) && !bvalid_q && !hold;
      wready_q <= !w_have_q && !(s_axi_wvalid && wready_q) && !bvalid_q && !hold;
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !bvalid_q) begin
        wr_en_q <= 1'b1;
        bvalid_q <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        arready_q <= 1'b0;
      end else begin
        if (rvalid_q && s_axi_rready) begin
          rvalid_q <= 1'b0;
        end
        arready_q <= !rvalid_q;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = 2'h0;
  assign wr_en = wr_en_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = s_axi_araddr;
endmodule // iof_axil

// ### verif/iof_top_properties.sv
// Purpose: concurrent checks on the front end pins
// Assumes: polarity strap held steady
// Notes: checks idle for 15 edges after reset
`timescale 1ns/1ps
module iof_props (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // User side
  input wire [15:0] user_dout,
  input wire no_operation_strobe,
  input wire input_a_strobe,
  input wire input_b_strobe,
  input wire input_c_strobe,
  input wire output_a_strobe,
  input wire output_b_strobe,
  input wire output_c_strobe,
  input wire start_strobe,
  input wire clear_strobe,
  input wire special_pulse_strobe,
  input wire mask_out_strobe,
  input wire dch_xfer_strobe,
  // Bus side
  input wire busy_select_line,
  input wire done_select_line,
  input wire int_req,
  input wire dch_req,
  input wire prio_out,
  input wire strap_polarity
);
  reg [3:0] warm_q;
  wire [3:0] warm_d = (warm_q == 4'hF) ? warm_q : warm_q + 4'h1;
  wire [11:0] act = {dch_xfer_strobe, mask_out_strobe, special_pulse_strobe, clear_strobe,
    start_strobe, output_c_strobe, output_b_strobe, output_a_strobe, input_c_strobe,
    input_b_strobe, input_a_strobe, no_operation_strobe} ~^ {12{strap_polarity}};
  wire cmd_any = |act[6:0];
  // Strobe levels mean nothing until the straps settle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) warm_q <= 4'h0;
    else warm_q <= warm_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || warm_q != 4'hF);
  sequence s_quiet(sig);
    !sig [*2];
  endsequence
  AST_START_PULSE: assert property ($rose(act[7]) |=> s_quiet(act[7]))
    else $error("start strobe too long");
  AST_CLEAR_INT: assert property (act[8] |-> ##[1:3] !int_req)
    else $error("request kept after clear");
  AST_PULSE_INT: assert property (act[9] |-> ##[1:3] !int_req)
    else $error("request kept after pulse");
  AST_FLAG_ORDER: assert property ((|act[9:7]) |-> $past(cmd_any, 2))
    else $error("flag strobe without command strobe");
  AST_BUSY_SEL: assert property ($rose(busy_select_line) |=> s_quiet(busy_select_line))
    else $error("busy select too long");
  AST_DONE_SEL: assert property ($rose(done_select_line) |=> s_quiet(done_select_line))
    else $error("done select too long");
  AST_PRIO: assert property (int_req |=> !prio_out)
    else $error("priority passed while requesting");
  AST_DOUT_CAUSE: assert property ($changed(user_dout) |->
    act[11] || $past(|act[6:4]) || $past(act[10]))
    else $error("output word moved without strobe");
  AST_DCH_STEP: assert property (act[11] |-> $past(dch_req) ##[0:1] !dch_req)
    else $error("channel transfer without request");
endmodule // iof_props

bind iof_top iof_props iof_props_i (.*);

// ### verif/iof_user_model.sv
// Purpose: user logic behind the front end
// Assumes: strobes given active high
// Notes: dly of 0 means the operation never ends
`timescale 1ns/1ps
module iof_user_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // From the front end
  input wire [15:0] user_dout,
  input wire out_any,
  input wire start_on,
  input wire clear_on,
  // Bench control
  input wire [7:0] dly,
  // To the front end
  output reg [15:0] user_din,
  output reg dev_complete
);
  reg pend_q;
  reg [7:0] cnt_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'h0;
      cnt_q <= 8'h00;
      user_din <= 16'h0000;
      dev_complete <= 1'h0;
    end else begin
      pend_q <= out_any;
      // Word held steady long before any capture, as the inputs are synchronised
      if (pend_q) user_din <= user_dout;
      if (start_on) cnt_q <= dly;
      else if (clear_on) cnt_q <= 8'h00;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      dev_complete <= (cnt_q != 8'h00) && (cnt_q < 8'h04);
    end
  end
endmodule // iof_user_model

// ### verif/iof_top_test.sv
// Purpose: self-checking bench for the front end
// Assumes: polarity strap fitted, external strap absent
// Notes: seeded random words
`timescale 1ns/1ps
`include "iof_defs.vh"
module iof_top_test;
  logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dly;
  logic [31:0] s_axi_wdata, v;
  logic [3:0] s_axi_wstrb;
  logic dch_req_in, prio_in, strap_external, strap_polarity;
  logic [5:0] strap_dev_code, dev_v;
  logic [15:0] w;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] user_din, user_dout;
  wire no_operation_strobe, input_a_strobe, input_b_strobe, input_c_strobe, output_a_strobe;
  wire output_b_strobe, output_c_strobe, start_strobe, clear_strobe, special_pulse_strobe;
  wire mask_out_strobe, dch_xfer_strobe, dev_complete, busy_select_line, done_select_line;
  wire int_req, dch_req, prio_out;
  int failures, tests_run, seed_v;
  iof_top #(.AW(8)) iof_top_i (.*);
  iof_user_model iof_user_model_i (.clk, .rst_n, .user_dout, .dly, .user_din, .dev_complete,
    .out_any(output_a_strobe | output_b_strobe | output_c_strobe | dch_xfer_strobe),
    .start_on(start_strobe), .clear_on(clear_strobe));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ra, rw, rb;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      {ra, rw, rb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge clk);
      n++;
      if (ra) s_axi_awvalid <= 1'h0;
      if (rw) s_axi_wvalid <= 1'h0;
    end while (!rb && n < 200);
    s_axi_bready <= 1'h0;
    if (n >= 200) failures++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    logic ra, rb;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      {ra, rb} = {s_axi_arready, s_axi_rvalid};
      d = s_axi_rdata;
      @(posedge clk);
      n++;
      if (ra) s_axi_arvalid <= 1'h0;
    end while (!rb && n < 200);
    s_axi_rready <= 1'h0;
    if (n >= 200) failures++;
  endtask
  // Waits six cycles past the response; the sequence itself takes three
  task automatic ins(input logic [2:0] x, input logic [1:0] f, input logic [5:0] dv);
    wr(`IOF_A_INSTR, {21'h0, x, f, dv});
    repeat (6) @(posedge clk);
  endtask
  task automatic st;
    rd(`IOF_A_STATUS, v);
  endtask
  function automatic logic skip_exp(input logic [1:0] t, input logic b, input logic d);
    skip_exp = (t[1] ? d : b) ^ t[0];
  endfunction
  task automatic skips(input logic b, input logic d);
    for (int t = 0; t < 4; t++) begin
      ins(`IOF_X_TEST, t[1:0], dev_v);
      st;
      chk({31'h0, v[7]}, {31'h0, skip_exp(t[1:0], b, d)});
    end
  endtask
  task automatic wait_int;
    int n;
    n = 0;
    while (int_req !== 1'h1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, int_req}, 32'h1);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    wrap_up;
  end
  initial begin
    rst_n = 1'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    dly = 8'h00;
    dch_req_in = 1'h0;
    prio_in = 1'h1;
    strap_external = 1'h0;
    strap_polarity = 1'h1;
    dev_v = 6'h15;
    strap_dev_code = 6'h15;
    failures = 0;
    tests_run = 0;
    seed_v = $urandom(32'h9B09E598);
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (8) @(posedge clk);
    st;
    chk(v & 32'hFDFF, {16'h0, dev_v, 10'h040});
    w = $urandom;
    wr(`IOF_A_ACC, {16'h0, w});
    rd(`IOF_A_ACC, v);
    chk(v, {16'h0, w});
    wr(8'h14, $urandom);
    rd(8'h14, v);
    chk(v, 32'h0);
    for (int i = 0; i < 2; i++) begin
      w = $urandom;
      wr(`IOF_A_ACC, {16'h0, w});
      ins(i ? `IOF_X_OUT_C : `IOF_X_OUT_A, `IOF_FN_NONE, dev_v);
      chk({16'h0, user_dout}, {16'h0, w});
      ins(i ? `IOF_X_IN_C : `IOF_X_IN_A, `IOF_FN_NONE, dev_v);
      rd(`IOF_A_INPUT, v);
      chk(v, {16'h0, w});
    end
    $display("test transfers done");
    dly <= 8'hC8;
    ins(`IOF_X_NONE, `IOF_FN_START, dev_v);
    st;
    chk(v & 32'h3, 32'h1);
    skips(1'h1, 1'h0);
    ins(`IOF_X_NONE, `IOF_FN_PULSE, dev_v);
    st;
    chk(v & 32'h3, 32'h1);
    wait_int;
    st;
    chk(v & 32'h3, 32'h2);
    skips(1'h0, 1'h1);
    ins(`IOF_X_NONE, `IOF_FN_PULSE, dev_v);
    st;
    chk(v & 32'h7, 32'h0);
    ins(`IOF_X_NONE, `IOF_FN_START, dev_v ^ 6'h01);
    st;
    chk(v & 32'h3, 32'h0);
    ins(`IOF_X_NONE, `IOF_FN_START, dev_v);
    ins(`IOF_X_NONE, `IOF_FN_CLEAR, dev_v);
    st;
    chk(v & 32'h3, 32'h0);
    $display("test flags done");
    dly <= 8'h06;
    wr(`IOF_A_ACC, 32'h8421);
    ins(`IOF_X_OUT_A, `IOF_FN_START, dev_v);
    wait_int;
    for (int i = 0; i < 2; i++) begin
      wr(`IOF_A_ACC, i ? 32'h2 : 32'h1);
      ins(`IOF_X_OUT_B, `IOF_FN_NONE, `IOF_DEV_CPU);
      st;
      chk(v & 32'hF, i ? 32'h6 : 32'hA);
    end
    for (int i = 0; i < 2; i++) begin
      prio_in <= (i == 0);
      repeat (4) @(posedge clk);
      ins(`IOF_X_IN_B, `IOF_FN_NONE, `IOF_DEV_CPU);
      rd(`IOF_A_INPUT, v);
      chk(v, i ? 32'h0 : {26'h0, dev_v});
    end
    prio_in <= 1'h1;
    strap_dev_code <= 6'h2A;
    ins(`IOF_X_OUT_A, `IOF_FN_NONE, `IOF_DEV_CPU);
    repeat (4) @(posedge clk);
    dev_v = 6'h2A;
    st;
    chk(v & 32'hFC47, {16'h0, dev_v, 10'h040});
    $display("test interrupts done");
    w = $urandom | 16'h7FFF;
    wr(`IOF_A_ACC, {16'h0, w});
    ins(`IOF_X_OUT_B, `IOF_FN_NONE, dev_v);
    rd(`IOF_A_ADDR, v);
    chk(v, 32'h7FFF);
    ins(`IOF_X_IN_B, `IOF_FN_NONE, dev_v);
    rd(`IOF_A_INPUT, v);
    chk(v, 32'h7FFF);
    wr(`IOF_A_ACC, 32'hFFFF);
    ins(`IOF_X_OUT_C, `IOF_FN_NONE, dev_v);
    dch_req_in <= 1'h1;
    repeat (6) @(posedge clk);
    st;
    chk(v & 32'h13, 32'h10);
    w = $urandom;
    wr(`IOF_A_DCH, {16'h0, w});
    repeat (2) @(posedge clk);
    chk({16'h0, user_dout}, {16'h0, w});
    rd(`IOF_A_ADDR, v);
    chk(v, 32'h0);
    st;
    chk(v & 32'h13, 32'h2);
    dch_req_in <= 1'h0;
    $display("test channel done");
    wrap_up;
  end
endmodule // iof_top_test
